// ---- ddr2w_pkg.sv ----
// Shared constants, types and helpers for the write-path memory controller.
package ddr2w_pkg;

  localparam int BANKS = 4;
  localparam int BANK_W = 2;
  localparam int ADDR_W = 14;
  localparam int CNT_W = 6;
  localparam int MAX_BL = 8;
  localparam int AP_BIT = 10;
  localparam int INTR_GAP = 2;
  localparam int WTR_MIN_CK = 2;

  localparam int SYS_PERIOD_PS = 10000;
  localparam int WR_REC_PS = 15000;
  localparam int WR_TO_RD_PS = 7500;
  localparam int ROW_PRE_PS = 15000;

  localparam int CK_HALF_DEF = 4;
  localparam int CAS_LAT_DEF = 3;
  localparam int ADD_LAT_DEF = 0;
  localparam int BURST_LEN_DEF = 4;
  localparam int DQ_W_DEF = 8;

  typedef enum logic [2:0] {
    OP_NOP = 3'h0,
    OP_ACT = 3'h1,
    OP_READ = 3'h2,
    OP_WRITE = 3'h3,
    OP_PRE = 3'h4
  } op_type;

  typedef struct packed {
    op_type op;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic auto_pre;
    logic other_rank;
  } cmd_type;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] a;
  } pins_type;

  localparam pins_type PINS_IDLE = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                                     we_n: 1'b1, ba: 2'h0, a: 14'h0};

  function automatic int ceil_div(input int n, input int d);
    return (n + d - 1) / d;
  endfunction : ceil_div

  // Drives the command pins for one command; the select line carries A10.
  function automatic pins_type cmd_pins(input cmd_type c);
    pins_type p;
    p = '{cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
          ba: c.bank, a: c.addr};
    case (c.op)
      OP_ACT: begin
        p.ras_n = 1'b0;
      end
      OP_READ: begin
        p.cas_n = 1'b0;
        p.a[AP_BIT] = c.auto_pre;
      end
      OP_WRITE: begin
        p.cas_n = 1'b0;
        p.we_n = 1'b0;
        p.a[AP_BIT] = c.auto_pre;
      end
      OP_PRE: begin
        p.ras_n = 1'b0;
        p.we_n = 1'b0;
        p.a[AP_BIT] = c.auto_pre;
      end
      default: begin
        p.a = 14'h0;
      end
    endcase
    return p;
  endfunction : cmd_pins

endpackage : ddr2w_pkg

// ---- ck_phase_gen.sv ----
// Divides the system clock into the memory clock and reports its phase.
`timescale 1ns/1ps
module ck_phase_gen #(
  parameter int HALF = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic ck,
  output logic [$clog2(2*HALF)-1:0] phase
);

  localparam int PW = $clog2(2*HALF);
  localparam logic [PW-1:0] LAST = PW'(2*HALF - 1);
  localparam logic [PW-1:0] HALF_P = PW'(HALF);

  typedef struct packed {
    logic [PW-1:0] cnt;
    logic ck;
  } div_type;

  div_type s_q;
  div_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.cnt = (s_q.cnt == LAST) ? '0 : s_q.cnt + 1'b1;
    s_d.ck = (s_d.cnt < HALF_P);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '{cnt: LAST, ck: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign ck = s_q.ck;
  assign phase = s_q.cnt;

endmodule : ck_phase_gen

// ---- bank_guard.sv ----
// Per-bank countdown that holds off commands until a bank's wait is over.
`timescale 1ns/1ps
module bank_guard #(
  parameter int BANKS = 4,
  parameter int CW = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic set_en,
  input wire logic set_all,
  input wire logic [$clog2(BANKS)-1:0] set_bank,
  input wire logic [CW-1:0] set_val,
  output logic [BANKS-1:0] busy
);

  typedef struct packed {
    logic [BANKS-1:0][CW-1:0] cnt;
  } guard_type;

  guard_type s_q;
  guard_type s_d;

  always_comb begin
    s_d = s_q;
    for (int b = 0; b < BANKS; b++) begin
      if (tick && s_q.cnt[b] != '0) begin
        s_d.cnt[b] = s_q.cnt[b] - 1'b1;
      end
      if (set_en && (set_all || set_bank == b[$clog2(BANKS)-1:0]) &&
          set_val >= s_d.cnt[b]) begin
        s_d.cnt[b] = set_val;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    for (int b = 0; b < BANKS; b++) begin
      busy[b] = (s_q.cnt[b] != '0);
    end
  end

endmodule : bank_guard

// ---- ddr2_write_host.sv ----
// Host-side controller that drives write bursts into the memory pins.
// Function
// - Select line high enables auto precharge.
// - Strobe low before first and after last.
// - First rising strobe one write latency later.
// - Gapless writes spaced half a burst apart.
// - Four-element bursts never interrupted.
// - Eight-element burst cut only by write.
// - Interrupting write exactly two clocks later.
// - Only idle commands between interrupted writes.
// - Interrupting write picks bank, precharge freely.
// - Truncated write precharge waits full burst.
// - Read waits write-to-read delay, two minimum.
// - Other rank reads skip write-to-read delay.
// - Same-bank precharge waits write recovery time.
// - Other-bank precharge needs no recovery wait.
// - Read after auto precharge write waits longer; the code waits the same write-to-read delay as after a plain write.
// - After auto precharge, writes wait half burst.
// - Clock enable stays high through bursts.
`timescale 1ns/1ps
module ddr2_write_host #(
  parameter int CK_HALF = ddr2w_pkg::CK_HALF_DEF,
  parameter int CAS_LAT = ddr2w_pkg::CAS_LAT_DEF,
  parameter int ADD_LAT = ddr2w_pkg::ADD_LAT_DEF,
  parameter int BURST_LEN = ddr2w_pkg::BURST_LEN_DEF,
  parameter int DQ_W = ddr2w_pkg::DQ_W_DEF
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic CMD_VALID,
  input wire ddr2w_pkg::cmd_type CMD,
  input wire logic [ddr2w_pkg::MAX_BL*DQ_W-1:0] WDATA,
  input wire logic [ddr2w_pkg::MAX_BL-1:0] WMASK,
  output logic CMD_READY,
  output logic WR_BUSY,
  output logic [2:0] WR_SETTING,
  output logic MEM_CK,
  output logic MEM_CKE,
  output ddr2w_pkg::pins_type MEM_CMD,
  output logic DQS_O,
  output logic DQS_OE_N,
  output logic [DQ_W-1:0] DQ_O,
  output logic DQ_OE_N,
  output logic DM
);

  localparam int CW = ddr2w_pkg::CNT_W;
  localparam int PW = $clog2(2*CK_HALF);
  localparam int DW = ddr2w_pkg::MAX_BL * DQ_W;
  localparam int CK_PS = 2 * CK_HALF * ddr2w_pkg::SYS_PERIOD_PS;
  localparam int WL = CAS_LAT + ADD_LAT - 1;
  localparam int HB = BURST_LEN / 2;
  localparam int WR_RAW = ddr2w_pkg::ceil_div(ddr2w_pkg::WR_REC_PS, CK_PS);
  localparam int WR_CK = (WR_RAW < 1) ? 1 : WR_RAW;
  localparam int WTR_RAW = ddr2w_pkg::ceil_div(ddr2w_pkg::WR_TO_RD_PS, CK_PS);
  localparam int WTR_CK = (WTR_RAW < ddr2w_pkg::WTR_MIN_CK) ?
                          ddr2w_pkg::WTR_MIN_CK : WTR_RAW;
  localparam int RP_RAW = ddr2w_pkg::ceil_div(ddr2w_pkg::ROW_PRE_PS, CK_PS);
  localparam int RP_CK = (RP_RAW < 1) ? 1 : RP_RAW;
  localparam logic IS_BL8 = (BURST_LEN == ddr2w_pkg::MAX_BL);

  localparam logic [PW-1:0] PH_RISE = PW'(0);
  localparam logic [PW-1:0] PH_FALL = PW'(CK_HALF);
  localparam logic [PW-1:0] PH_DQ_A = PW'(CK_HALF + CK_HALF / 2);
  localparam logic [PW-1:0] PH_DQ_B = PW'(CK_HALF / 2);

  localparam logic [CW-1:0] WW_WAIT = CW'(HB - 1);
  localparam logic [CW-1:0] INTR_AT = CW'(HB - ddr2w_pkg::INTR_GAP);
  localparam logic [CW-1:0] WTR_WAIT = CW'(WL + HB + WTR_CK - 1);
  localparam logic [CW-1:0] NW_WAIT = CW'(HB - 1);
  localparam logic [CW-1:0] WPRE_WAIT = CW'(WL + HB + WR_CK - 1);
  localparam logic [CW-1:0] AP_WAIT = CW'(WL + HB + WR_CK + RP_CK - 1);
  localparam logic [CW-1:0] RP_WAIT = CW'(RP_CK - 1);
  localparam logic [CW-1:0] WL_CNT = CW'(WL);
  localparam logic [3:0] BL_CNT = 4'(BURST_LEN);

  typedef enum logic [1:0] {
    ST_INIT = 2'b01,
    ST_RUN = 2'b10
  } state_type;

  typedef struct packed {
    state_type st;
    logic cke;
    ddr2w_pkg::pins_type pins;
    logic dqs;
    logic dqs_oe_n;
    logic dq_oe_n;
    logic [1:0] pv;
    logic [1:0][CW-1:0] pc;
    logic [1:0][DW-1:0] pd;
    logic [1:0][ddr2w_pkg::MAX_BL-1:0] pm;
    logic [3:0] left;
    logic [DW-1:0] cd;
    logic [ddr2w_pkg::MAX_BL-1:0] cm;
    logic post;
    logic [CW-1:0] wr_cnt;
    logic [CW-1:0] rd_cnt;
    logic [CW-1:0] nw_cnt;
    logic last_ap;
    logic [ddr2w_pkg::BANKS-1:0] open;
  } regs_type;

  localparam regs_type RST_VAL = '{st: ST_INIT, pins: ddr2w_pkg::PINS_IDLE,
                                   dqs_oe_n: 1'b1, dq_oe_n: 1'b1,
                                   default: '0};

  localparam ddr2w_pkg::cmd_type NOP_CMD = '{op: ddr2w_pkg::OP_NOP,
                                            default: '0};

  regs_type s_q;
  regs_type s_d;
  logic ck;
  logic [PW-1:0] ph;
  logic tick;
  logic ok;
  logic accept;
  logic intr_ok;
  logic ld;
  logic li;
  logic preamb;
  logic pg_set;
  logic ag_set;
  logic ag_all;
  logic [CW-1:0] ag_val;
  logic [ddr2w_pkg::BANKS-1:0] pre_busy;
  logic [ddr2w_pkg::BANKS-1:0] act_busy;

  ck_phase_gen #(
    .HALF(CK_HALF)
  ) u_div (
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .ck(ck),
    .phase(ph)
  );

  bank_guard #(
    .BANKS(ddr2w_pkg::BANKS),
    .CW(CW)
  ) u_pre_guard (
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .tick(tick),
    .set_en(pg_set),
    .set_all(1'b0),
    .set_bank(CMD.bank),
    .set_val(WPRE_WAIT),
    .busy(pre_busy)
  );

  bank_guard #(
    .BANKS(ddr2w_pkg::BANKS),
    .CW(CW)
  ) u_act_guard (
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .tick(tick),
    .set_en(ag_set),
    .set_all(ag_all),
    .set_bank(CMD.bank),
    .set_val(ag_val),
    .busy(act_busy)
  );

  assign tick = (ph == PH_FALL);

  // Decides whether the offered command may go out on this clock.
  always_comb begin
    intr_ok = IS_BL8 && !s_q.last_ap && (s_q.wr_cnt == INTR_AT);
    case (CMD.op)
      ddr2w_pkg::OP_WRITE: begin
        ok = (s_q.wr_cnt == '0 || intr_ok) && !act_busy[CMD.bank] &&
             s_q.open[CMD.bank] && !(&s_q.pv);
      end
      ddr2w_pkg::OP_READ: begin
        ok = (s_q.rd_cnt == '0 || CMD.other_rank) && s_q.nw_cnt == '0 &&
             !act_busy[CMD.bank] && s_q.open[CMD.bank];
      end
      ddr2w_pkg::OP_PRE: begin
        ok = s_q.nw_cnt == '0 && (CMD.auto_pre ?
             (pre_busy == '0 && act_busy == '0) :
             (!pre_busy[CMD.bank] && !act_busy[CMD.bank]));
      end
      ddr2w_pkg::OP_ACT: begin
        ok = s_q.nw_cnt == '0 && !act_busy[CMD.bank] &&
             !s_q.open[CMD.bank];
      end
      default: begin
        ok = 1'b1;
      end
    endcase
    CMD_READY = (s_q.st == ST_RUN) && tick && ok;
    accept = CMD_READY && CMD_VALID;
  end

  always_comb begin
    s_d = s_q;
    pg_set = 1'b0;
    ag_set = 1'b0;
    ag_all = 1'b0;
    ag_val = RP_WAIT;
    ld = 1'b0;
    li = 1'b0;
    preamb = 1'b0;
    case (s_q.st)
      ST_INIT: begin
        if (tick) begin
          s_d.st = ST_RUN;
          s_d.cke = 1'b1;
          s_d.pins = ddr2w_pkg::cmd_pins(NOP_CMD);
        end
      end
      ST_RUN: begin
        if (tick) begin
          if (s_q.wr_cnt != '0) begin
            s_d.wr_cnt = s_q.wr_cnt - 1'b1;
          end
          if (s_q.rd_cnt != '0) begin
            s_d.rd_cnt = s_q.rd_cnt - 1'b1;
          end
          if (s_q.nw_cnt != '0) begin
            s_d.nw_cnt = s_q.nw_cnt - 1'b1;
          end
          for (int i = 0; i < 2; i++) begin
            if (s_q.pv[i] && s_q.pc[i] != '0) begin
              s_d.pc[i] = s_q.pc[i] - 1'b1;
            end
          end
          s_d.pins = ddr2w_pkg::cmd_pins(accept ? CMD : NOP_CMD);
          if (accept) begin
            case (CMD.op)
              ddr2w_pkg::OP_WRITE: begin
                s_d.wr_cnt = WW_WAIT;
                s_d.rd_cnt = WTR_WAIT;
                s_d.nw_cnt = (IS_BL8 && !CMD.auto_pre) ? NW_WAIT : '0;
                s_d.last_ap = CMD.auto_pre;
                li = s_q.pv[0];
                s_d.pv[li] = 1'b1;
                s_d.pc[li] = WL_CNT;
                s_d.pd[li] = WDATA;
                s_d.pm[li] = WMASK;
                pg_set = 1'b1;
                if (CMD.auto_pre) begin
                  ag_set = 1'b1;
                  ag_val = AP_WAIT;
                  s_d.open[CMD.bank] = 1'b0;
                end
              end
              ddr2w_pkg::OP_READ: begin
                if (CMD.auto_pre) begin
                  s_d.open[CMD.bank] = 1'b0;
                  ag_set = 1'b1;
                end
              end
              ddr2w_pkg::OP_PRE: begin
                ag_set = 1'b1;
                ag_all = CMD.auto_pre;
                if (CMD.auto_pre) begin
                  s_d.open = '0;
                end else begin
                  s_d.open[CMD.bank] = 1'b0;
                end
              end
              ddr2w_pkg::OP_ACT: begin
                s_d.open[CMD.bank] = 1'b1;
              end
              default: begin
                s_d.open = s_q.open;
              end
            endcase
          end
        end
      end
      default: begin
        s_d = RST_VAL;
      end
    endcase

    // Data steps a quarter clock ahead of each strobe edge.
    if (ph == PH_DQ_A || ph == PH_DQ_B) begin
      for (int i = 0; i < 2; i++) begin
        if (ph == PH_DQ_A && s_q.pv[i] && s_q.pc[i] == '0) begin
          ld = 1'b1;
          li = i[0];
        end
      end
      if (ld) begin
        s_d.cd = s_q.pd[li];
        s_d.cm = s_q.pm[li];
        s_d.left = BL_CNT;
        s_d.pv[li] = 1'b0;
        s_d.post = 1'b0;
      end else if (s_q.left != 4'h0) begin
        s_d.cd = s_q.cd >> DQ_W;
        s_d.cm = s_q.cm >> 1;
        s_d.left = s_q.left - 4'h1;
        s_d.post = (s_q.left == 4'h1);
      end else begin
        s_d.post = 1'b0;
      end
    end
    if (ph == PH_RISE) begin
      s_d.dqs = (s_q.left != 4'h0);
    end else if (ph == PH_FALL) begin
      s_d.dqs = 1'b0;
    end
    for (int i = 0; i < 2; i++) begin
      if (s_d.pv[i] && s_d.pc[i] == '0) begin
        preamb = 1'b1;
      end
    end
    s_d.dqs_oe_n = !(preamb || s_d.left != 4'h0 || s_d.post);
    s_d.dq_oe_n = (s_d.left == 4'h0);
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      s_q <= RST_VAL;
    end else begin
      s_q <= s_d;
    end
  end

  assign WR_BUSY = (s_q.left != 4'h0) || (|s_q.pv) || s_q.post;
  assign WR_SETTING = 3'(WR_CK);
  assign MEM_CK = ck;
  assign MEM_CKE = s_q.cke;
  assign MEM_CMD = s_q.pins;
  assign DQS_O = s_q.dqs;
  assign DQS_OE_N = s_q.dqs_oe_n;
  assign DQ_O = s_q.cd[DQ_W-1:0];
  assign DQ_OE_N = s_q.dq_oe_n;
  assign DM = s_q.cm[0];

endmodule : ddr2_write_host

// ---- ddr2w_chk_sva.sv ----
// Port checker for the write-path controller.
`timescale 1ns/1ps
module ddr2w_chk #(
  parameter int CK_HALF = 4,
  parameter int CAS_LAT = 3,
  parameter int ADD_LAT = 0,
  parameter int BURST_LEN = 4
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic CMD_VALID,
  input wire ddr2w_pkg::cmd_type CMD,
  input wire logic CMD_READY,
  input wire logic WR_BUSY,
  input wire logic MEM_CKE,
  input wire ddr2w_pkg::pins_type MEM_CMD,
  input wire logic DQS_O,
  input wire logic DQS_OE_N,
  input wire logic DQ_OE_N
);
  localparam int PER = 2 * CK_HALF;
  localparam int WL = CAS_LAT + ADD_LAT - 1;
  localparam int DQS_A = PER * WL + CK_HALF;
  localparam int DQS_B = DQS_A + 1;
  localparam int RD_GAP = PER * (WL + BURST_LEN / 2 + 2);
  localparam int PRE_GAP = PER * (WL + BURST_LEN / 2 + 1);
  logic tk;
  logic wr;
  logic [7:0] wcnt_q;
  logic [1:0] wbank_q;
  assign tk = CMD_VALID && CMD_READY;
  assign wr = tk && CMD.op == ddr2w_pkg::OP_WRITE;
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      wcnt_q <= 8'hFF;
      wbank_q <= 2'h0;
    end else if (wr) begin
      wcnt_q <= 8'h01;
      wbank_q <= CMD.bank;
    end else if (wcnt_q != 8'hFF) begin
      wcnt_q <= wcnt_q + 8'h01;
    end
  end
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);
  property p_cke;
    WR_BUSY |-> MEM_CKE;
  endproperty
  a_cke: assert property (p_cke)
    else $error("clock enable low in a write");
  property p_pins;
    wr |=> !MEM_CMD.cs_n && MEM_CMD.ras_n && !MEM_CMD.cas_n && !MEM_CMD.we_n
      && MEM_CMD.ba == $past(CMD.bank) && MEM_CMD.a[10] == $past(CMD.auto_pre)
      && MEM_CMD.a[9:0] == $past(CMD.addr[9:0]);
  endproperty
  a_pins: assert property (p_pins)
    else $error("write pins wrong");
  property p_one;
    tk |=> !CMD_READY [*7];
  endproperty
  a_one: assert property (p_one)
    else $error("two commands in one clock");
  property p_whole;
    wr |=> !wr [*8];
  endproperty
  a_whole: assert property (p_whole)
    else $error("write burst cut short");
  property p_lat;
    wr |-> ##[DQS_A:DQS_B] $rose(DQS_O);
  endproperty
  a_lat: assert property (p_lat)
    else $error("first strobe rise misplaced");
  property p_pre;
    $fell(DQ_OE_N) |-> !DQS_OE_N && !DQS_O;
  endproperty
  a_pre: assert property (p_pre)
    else $error("no strobe preamble");
  property p_post;
    $rose(DQ_OE_N) |-> !DQS_OE_N && !DQS_O;
  endproperty
  a_post: assert property (p_post)
    else $error("no strobe postamble");
  property p_idle;
    !WR_BUSY |-> DQ_OE_N && DQS_OE_N;
  endproperty
  a_idle: assert property (p_idle)
    else $error("lines driven while idle");
  property p_rd;
    tk && CMD.op == ddr2w_pkg::OP_READ && !CMD.other_rank
      |-> int'(wcnt_q) >= RD_GAP;
  endproperty
  a_rd: assert property (p_rd)
    else $error("read too soon after write");
  property p_prec;
    tk && CMD.op == ddr2w_pkg::OP_PRE && (CMD.bank == wbank_q || CMD.auto_pre)
      |-> int'(wcnt_q) >= PRE_GAP;
  endproperty
  a_prec: assert property (p_prec)
    else $error("precharge too soon after write");
endmodule : ddr2w_chk
bind ddr2_write_host ddr2w_chk #(.CK_HALF(CK_HALF), .CAS_LAT(CAS_LAT),
  .ADD_LAT(ADD_LAT), .BURST_LEN(BURST_LEN)) u_chk (.CLK_SYS(CLK_SYS),
  .RSTN(RSTN), .CMD_VALID(CMD_VALID), .CMD(CMD), .CMD_READY(CMD_READY),
  .WR_BUSY(WR_BUSY), .MEM_CKE(MEM_CKE), .MEM_CMD(MEM_CMD), .DQS_O(DQS_O),
  .DQS_OE_N(DQS_OE_N), .DQ_OE_N(DQ_OE_N));

// ---- mem_model.sv ----
// Behavioural memory device on the write path, sampled by the system clock.
`timescale 1ns/1ps
module mem_model #(
  parameter int WL = 2,
  parameter int BL = 4
) (
  input wire logic CLK_SYS,
  input wire logic MEM_CK,
  input wire logic MEM_CKE,
  input wire ddr2w_pkg::pins_type MEM_CMD,
  input wire logic DQS_O,
  input wire logic DQS_OE_N,
  input wire logic [7:0] DQ_O,
  input wire logic DQ_OE_N,
  input wire logic DM
);
  logic [3:0] open_q = 4'h0;
  logic [63:0] bursts[$];
  logic [2:0] apq[$];
  int due[$];
  int n_bad = 0;
  int mcnt = 0;
  int k = 0;
  logic ck_p = 1'b0;
  logic dqs_p = 1'b0;
  logic [31:0] d = 32'h0;
  logic [3:0] m = 4'h0;
  logic [2:0] ap;
  always @(posedge CLK_SYS) begin
    if (MEM_CK && !ck_p) begin
      mcnt++;
      if ((due.size() > 0 || k > 0) && !MEM_CKE) n_bad++;
      if (!MEM_CMD.cs_n && !MEM_CMD.ras_n && MEM_CMD.cas_n) begin
        if (MEM_CMD.we_n) open_q[MEM_CMD.ba] = 1'b1;
        else if (MEM_CMD.a[10]) open_q = 4'h0;
        else open_q[MEM_CMD.ba] = 1'b0;
      end
      if (!MEM_CMD.cs_n && MEM_CMD.ras_n && !MEM_CMD.cas_n) begin
        if (!open_q[MEM_CMD.ba]) n_bad++;
        if (!MEM_CMD.we_n) begin
          due.push_back(mcnt + WL);
          apq.push_back({MEM_CMD.a[10], MEM_CMD.ba});
        end
      end
    end
    if (DQS_O != dqs_p && !DQS_OE_N && !DQ_OE_N) begin
      if (k == 0) begin
        if (!DQS_O || due.size() == 0 || due[0] != mcnt) n_bad++;
        if (due.size() > 0) void'(due.pop_front());
      end
      d[8*k+:8] = DM ? 8'h00 : DQ_O;
      m[k] = DM;
      k++;
      if (k == BL) begin
        bursts.push_back(64'({m, d}));
        k = 0;
        if (apq.size() > 0) begin
          ap = apq.pop_front();
          if (ap[2]) open_q[ap[1:0]] = 1'b0;
        end
      end
    end
    ck_p = MEM_CK;
    dqs_p = DQS_O;
  end
endmodule : mem_model

// ---- tb.sv ----
// Self-checking bench for the write-path controller.
`timescale 1ns/1ps
module tb;
  localparam int PER = 2 * ddr2w_pkg::CK_HALF_DEF;
  localparam int WLC = ddr2w_pkg::CAS_LAT_DEF + ddr2w_pkg::ADD_LAT_DEF - 1;
  localparam int H = ddr2w_pkg::BURST_LEN_DEF / 2;
  localparam int WRC = (15000 + PER * 10000 - 1) / (PER * 10000);
  logic CLK_SYS = 1'b0;
  logic RSTN = 1'b0;
  logic CMD_VALID = 1'b0;
  ddr2w_pkg::cmd_type CMD = '0;
  logic [63:0] WDATA = 64'h0;
  logic [7:0] WMASK = 8'h0;
  logic CMD_READY, WR_BUSY, MEM_CK, MEM_CKE, DQS_O, DQS_OE_N, DQ_OE_N, DM;
  logic [2:0] WR_SETTING;
  ddr2w_pkg::pins_type MEM_CMD;
  logic [7:0] DQ_O;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  int t_gap = 0;
  int t_now = 0;
  logic [31:0] lfsr = 32'h0001222C;
  logic [63:0] exp_q[$];
  logic [2:0] sop [6] = '{3'h2, 3'h2, 3'h4, 3'h4, 3'h3, 3'h4};
  logic [1:0] sbk [6] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h0};
  int sgap [6] = '{PER * (WLC + H + 2), PER, PER * (WLC + H + WRC), PER,
                   PER * H, PER * (WLC + H + WRC)};
  always #5 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) cyc <= cyc + 1;
  ddr2_write_host dut (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .CMD_VALID(CMD_VALID),
    .CMD(CMD), .WDATA(WDATA), .WMASK(WMASK), .CMD_READY(CMD_READY),
    .WR_BUSY(WR_BUSY), .WR_SETTING(WR_SETTING), .MEM_CK(MEM_CK),
    .MEM_CKE(MEM_CKE), .MEM_CMD(MEM_CMD), .DQS_O(DQS_O),
    .DQS_OE_N(DQS_OE_N), .DQ_O(DQ_O), .DQ_OE_N(DQ_OE_N), .DM(DM));
  mem_model #(.WL(WLC), .BL(2 * H)) mem (.CLK_SYS(CLK_SYS), .MEM_CK(MEM_CK),
    .MEM_CKE(MEM_CKE), .MEM_CMD(MEM_CMD), .DQS_O(DQS_O),
    .DQS_OE_N(DQS_OE_N), .DQ_O(DQ_O), .DQ_OE_N(DQ_OE_N), .DM(DM));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction : nxt
  function automatic logic [63:0] exp_b(input logic [31:0] d,
                                        input logic [3:0] m);
    for (int i = 0; i < 4; i++) if (m[i]) d[8*i+:8] = 8'h00;
    return 64'({m, d});
  endfunction : exp_b
  task automatic chk(input string name, input logic [63:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic end_of_test();
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task automatic issue(input logic [2:0] op, input logic [1:0] bk,
                       input logic ap, input logic rk);
    int n;
    logic [31:0] dw;
    n = 0;
    @(posedge CLK_SYS);
    lfsr = nxt(lfsr);
    dw = nxt(lfsr);
    CMD_VALID <= 1'b1;
    CMD <= '{op: ddr2w_pkg::op_type'(op), bank: bk, addr: {4'h0, lfsr[9:0]},
             auto_pre: ap, other_rank: rk};
    WDATA <= {lfsr, dw};
    WMASK <= {4'h0, lfsr[7:4]};
    if (op == 3'h3) exp_q.push_back(exp_b(dw, lfsr[7:4]));
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (CMD_READY !== 1'b1 && n < 600);
    if (CMD_READY !== 1'b1) error_cnt++;
    CMD_VALID <= 1'b0;
    t_gap = cyc - t_now;
    t_now = cyc;
  endtask : issue
  task automatic idle();
    int n;
    n = 0;
    while (WR_BUSY !== 1'b0 && n < 600) begin
      @(posedge CLK_SYS);
      n++;
    end
    if (WR_BUSY !== 1'b0) error_cnt++;
    repeat (16) @(posedge CLK_SYS);
  endtask : idle
  initial begin
    #300000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    for (int b = 0; b < 4; b++) issue(3'h1, 2'(b), 1'b0, 1'b0);
    chk("cke", 64'(MEM_CKE), 64'h1);
    chk("wr_setting", 64'(WR_SETTING), 64'(WRC));
    for (int i = 0; i < 6; i++) begin
      issue(3'h3, lfsr[1:0], 1'b0, 1'b0);
      if (i > 0) chk("wr_gap", 64'(t_gap), 64'(PER * H));
    end
    idle();
    for (int s = 0; s < 6; s++) begin
      issue(3'h3, 2'h0, s == 4, 1'b0);
      issue(sop[s], sbk[s], s == 5, s == 1);
      chk("gap", 64'(t_gap), 64'(sgap[s]));
      idle();
      chk("open", 64'(mem.open_q[0]), 64'(s < 2 || s == 3));
      if (s >= 2) issue(3'h1, (s == 3) ? 2'h1 : 2'h0, 1'b0, 1'b0);
    end
    idle();
    chk("n_burst", 64'(mem.bursts.size()), 64'(exp_q.size()));
    while (mem.bursts.size() > 0 && exp_q.size() > 0)
      chk("burst", mem.bursts.pop_front(), exp_q.pop_front());
    chk("dev_bad", 64'(mem.n_bad), 64'h0);
    end_of_test();
  end
endmodule : tb
